// ### rtl/shr_pkg.sv
package shr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] CNT_OFF = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
  localparam logic [31:0] CTRL_WMASK = 32'h000F_FFFF;

  // ----------------------------------------------------------------
  // shared bus encodings and memory map
  // ----------------------------------------------------------------
  localparam logic [1:0] TT_NONSEQ = 2'h2;
  localparam logic [1:0] TT_SEQ = 2'h3;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam int IDX_W = 6;
  localparam int WORDS = 64;
  localparam logic [23:0] MAP_BASE = 24'h000000;
  localparam logic [5:0] PROT_FIRST = 6'h20;
  localparam logic [5:0] RO_FIRST = 6'h30;
  localparam logic [3:0] BURST_END = 4'hF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wait_resp;
    logic last_resp;
    logic error_resp;
  } shr_resp_t;

  localparam shr_resp_t RESP_DONE = '{wait_resp: 1'b0, last_resp: 1'b0, error_resp: 1'b0};
  localparam shr_resp_t RESP_ERROR = '{wait_resp: 1'b0, last_resp: 1'b0, error_resp: 1'b1};
  localparam shr_resp_t RESP_LAST = '{wait_resp: 1'b0, last_resp: 1'b1, error_resp: 1'b0};
  localparam shr_resp_t RESP_RETRACT = '{wait_resp: 1'b0, last_resp: 1'b1, error_resp: 1'b1};
  localparam shr_resp_t RESP_WAIT = '{wait_resp: 1'b1, last_resp: 1'b0, error_resp: 1'b0};
  localparam shr_resp_t RESP_WITHDRAW_NEXT = '{wait_resp: 1'b1, last_resp: 1'b1, error_resp: 1'b1};

  typedef struct packed {
    logic [1:0] transfer_type;
    logic [31:0] bus_addr;
    logic bus_write;
    logic [1:0] bus_size;
    logic [1:0] bus_prot;
  } shr_bus_req_t;

  typedef struct packed {
    logic [11:0] rsvd;
    logic prot_en;
    logic retract_en;
    logic last_en;
    logic err_en;
    logic [7:0] limit;
    logic [7:0] wait_cycles;
  } shr_ctrl_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_WITHDRAW, ST_GAP} shr_state_t;

endpackage

// ### rtl/shr_mem.sv
`timescale 1ns/1ps

module shr_mem (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // access port
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [shr_pkg::IDX_W-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  import shr_pkg::*;

  typedef struct packed {
    logic [WORDS-1:0][31:0] words;
    logic [31:0] rdata;
  } shr_mem_st_t;

  shr_mem_st_t s;
  shr_mem_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.rdata = s.words[addr];
    if (we) begin
      for (int b = 0; b < 4; b++) begin
        if (be[b]) begin
          next_s.words[addr][b*8 +: 8] = wdata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;

endmodule

// ### rtl/shr_bus_slave.sv
// Notes on behaviour
// - response codes: done, error, last, retract, wait
// - error for failure, unmapped, protection violation
// - without error checking, error stays low
// - after last, next sequential gets decode cycle
// - without burst limit, last stays low
// - withdraw: all high, then wait low
// - guaranteed-time slaves may skip withdraw support
// - a response is driven every cycle
// - decoder answers idle, decode, unmapped, protected, unaligned
// - response settled before the ending clock edge
// - response released leaving a turnaround phase; this slave keeps resp_oe high in every cycle out of reset
// - no data drive in first nonsequential phase
// - on writes the slave leaves data undriven
// - on reads slave drives data at completion
// - data moves over one shared 32-bit bus
// - arbiter grants; ownership when wait is low
// - wait high while more cycles are needed
// - lines undriven when unselected or in reset; here the response lines stay driven while slave_select is low
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps

module shr_bus_slave (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // shared bus request and response
  input wire shr_pkg::shr_bus_req_t bus_req,
  output shr_pkg::shr_resp_t response,
  output logic resp_oe,
  output logic slave_select,
  // shared data bus
  input wire logic [31:0] shared_data_bus_in,
  output logic [31:0] shared_data_bus_out,
  output logic shared_data_bus_oe
);
  import shr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    shr_state_t st;
    shr_resp_t resp;
    logic resp_oe;
    logic sel;
    logic [31:0] dout;
    logic dout_oe;
    logic [8:0] wcnt;
    logic [7:0] tcnt;
    logic after_last;
    logic is_write;
    logic [IDX_W-1:0] idx;
    logic [3:0] lanes;
    shr_ctrl_t ctrl;
    logic [7:0] n_retract;
    logic [7:0] n_error;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_off;
  } shr_regs_t;

  shr_regs_t s;
  shr_regs_t next_s;
  logic mem_we;
  logic [IDX_W-1:0] mem_addr;
  logic [31:0] mem_rdata;
  logic ev_err;
  logic ev_retract;
  logic cnt_clear;
  logic req_valid;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] lo);
    logic [3:0] m;
    m = 4'hF;
    if (size == SZ_BYTE) begin
      m = 4'(4'h1 << lo);
    end else if (size == SZ_HALF) begin
      m = lo[1] ? 4'hC : 4'h3;
    end
    return m;
  endfunction

  // faults answered by the decoder instead of the slave
  function automatic logic decode_fault(input shr_bus_req_t r, input shr_ctrl_t c);
    logic unmapped;
    logic unaligned;
    logic prot;
    unmapped = (r.bus_addr[31:8] != MAP_BASE);
    unaligned = (r.bus_size == SZ_WORD && r.bus_addr[1:0] != 2'h0) ||
                (r.bus_size == SZ_HALF && r.bus_addr[0]) || (r.bus_size == 2'h3);
    prot = c.prot_en && !r.bus_prot[1] && (r.bus_addr[7:2] >= PROT_FIRST);
    return unmapped || unaligned || prot;
  endfunction

  assign req_valid = (bus_req.transfer_type == TT_NONSEQ) || (bus_req.transfer_type == TT_SEQ);

  shr_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(mem_we),
    .be(s.lanes),
    .addr(mem_addr),
    .wdata(shared_data_bus_in),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_addr = s.idx;
    ev_err = 1'b0;
    ev_retract = 1'b0;
    cnt_clear = 1'b0;
    next_s.resp_oe = 1'b1;
    next_s.dout_oe = 1'b0;
    next_s.sel = 1'b0;
    case (s.st)
      ST_IDLE: begin
        next_s.resp = RESP_DONE;
        if (req_valid) begin
          next_s.idx = bus_req.bus_addr[7:2];
          next_s.is_write = bus_req.bus_write;
          next_s.lanes = lane_mask(bus_req.bus_size, bus_req.bus_addr[1:0]);
          mem_addr = bus_req.bus_addr[7:2];
          next_s.tcnt = 8'h00;
          next_s.after_last = 1'b0;
          if (decode_fault(bus_req, s.ctrl)) begin
            next_s.resp = RESP_ERROR;
            next_s.st = ST_GAP;
            ev_err = 1'b1;
          end else begin
            next_s.resp = RESP_WAIT;
            next_s.st = ST_ACCESS;
            next_s.sel = 1'b1;
            // a fresh decode costs one more wait cycle
            if (bus_req.transfer_type == TT_NONSEQ || s.after_last) begin
              next_s.wcnt = {1'b0, s.ctrl.wait_cycles} + 9'h001;
            end else begin
              next_s.wcnt = {1'b0, s.ctrl.wait_cycles};
            end
          end
        end
      end
      ST_ACCESS: begin
        next_s.tcnt = s.tcnt + 8'h01;
        if (s.ctrl.retract_en && s.tcnt >= s.ctrl.limit) begin
          next_s.resp = RESP_WITHDRAW_NEXT;
          next_s.st = ST_WITHDRAW;
          next_s.sel = 1'b1;
        end else if (s.wcnt != 9'h000) begin
          next_s.resp = RESP_WAIT;
          next_s.wcnt = s.wcnt - 9'h001;
          next_s.sel = 1'b1;
        end else begin
          // the bus may change hands only after this cycle with wait low
          next_s.st = ST_GAP;
          next_s.resp = RESP_DONE;
          if (s.is_write && s.idx >= RO_FIRST) begin
            // read-only words: the write is dropped either way
            if (s.ctrl.err_en) begin
              next_s.resp = RESP_ERROR;
              ev_err = 1'b1;
            end
          end else begin
            mem_we = s.is_write;
            if (s.ctrl.last_en && s.idx[3:0] == BURST_END) begin
              next_s.resp = RESP_LAST;
              next_s.after_last = 1'b1;
            end
          end
          next_s.dout = mem_rdata;
          next_s.dout_oe = !s.is_write;
        end
      end
      ST_WITHDRAW: begin
        next_s.resp = RESP_RETRACT;
        next_s.st = ST_GAP;
        ev_retract = 1'b1;
      end
      ST_GAP: begin
        // master's new request is not visible yet: hold it off one cycle
        next_s.resp = RESP_WAIT;
        next_s.st = ST_IDLE;
      end
      default: begin
        next_s.resp = RESP_DONE;
        next_s.st = ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // register bus slave, zero wait states
    // ----------------------------------------------------------------
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;
    next_s.ap_valid = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      next_s.ap_write = hwrite;
      next_s.ap_off = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          CTRL_OFF: next_s.hrdata = s.ctrl;
          STAT_OFF: next_s.hrdata = {26'h0, s.st != ST_IDLE, s.after_last, 1'b0, s.resp};
          CNT_OFF: next_s.hrdata = {16'h0, s.n_error, s.n_retract};
          default: next_s.hrdata = 32'h0000_0000;
        endcase
      end
    end
    if (s.ap_valid && s.ap_write) begin
      if (s.ap_off == CTRL_OFF) begin
        next_s.ctrl = hwdata & CTRL_WMASK;
      end
      cnt_clear = (s.ap_off == CNT_OFF);
    end
    // counters: an event in the clearing cycle still counts
    if (cnt_clear) begin
      next_s.n_error = {7'h00, ev_err};
      next_s.n_retract = {7'h00, ev_retract};
    end else begin
      next_s.n_error = s.n_error + {7'h00, ev_err};
      next_s.n_retract = s.n_retract + {7'h00, ev_retract};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ctrl <= CTRL_RESET;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign response = s.resp;
  assign resp_oe = s.resp_oe;
  assign slave_select = s.sel;
  assign shared_data_bus_out = s.dout;
  assign shared_data_bus_oe = s.dout_oe;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_no_reserved: assert property (
    resp_oe |-> !(response.wait_resp && (response.last_resp ^ response.error_resp)))
    else $error("reserved response code driven");

  chk_retract_pair: assert property (
    (resp_oe && response == RESP_WITHDRAW_NEXT) |=> (response == RESP_RETRACT) ##1
      response == RESP_WAIT)
    else $error("withdraw sequence broken");

  chk_always_driven: assert property (
    $past(hresetn) |-> resp_oe)
    else $error("response lines not driven");

  chk_decode_fault: assert property (
    (s.st == ST_IDLE && req_valid && decode_fault(bus_req, s.ctrl)) |=>
      (response == RESP_ERROR && !slave_select))
    else $error("decoder fault not answered with error");

  chk_decode_cycle: assert property (
    (s.st == ST_IDLE && bus_req.transfer_type == TT_NONSEQ && !decode_fault(bus_req, s.ctrl))
      |=> response.wait_resp && !shared_data_bus_oe ##1 response.wait_resp)
    else $error("nonsequential transfer lacks decode cycle");

  chk_last_reseq: assert property (
    (s.st == ST_IDLE && s.after_last && bus_req.transfer_type == TT_SEQ &&
      !decode_fault(bus_req, s.ctrl) && !s.ctrl.retract_en) |=> response.wait_resp [*2])
    else $error("sequential after last skipped decode cycle");

  chk_last_off: assert property (
    (!$past(s.ctrl.last_en) && response.last_resp) |-> response.error_resp)
    else $error("last response with burst limit off");

  chk_error_off: assert property (
    ($past(s.st) == ST_ACCESS && !$past(s.ctrl.err_en)) |-> !response.error_resp ||
      response.last_resp)
    else $error("slave error with error checking off");

  chk_write_quiet: assert property (
    (s.st == ST_GAP && s.is_write) |-> !shared_data_bus_oe)
    else $error("slave drove data on a write");

  chk_read_data: assert property (
    ($past(s.st) == ST_ACCESS && s.st == ST_GAP && !s.is_write && !response.wait_resp)
      |-> shared_data_bus_oe && shared_data_bus_out == $past(mem_rdata))
    else $error("read completion without data");

  chk_wait_length: assert property (
    (s.st == ST_ACCESS && s.wcnt != 9'h000 && !s.ctrl.retract_en) |=> response == RESP_WAIT)
    else $error("wait dropped before count expired");

endmodule

// ### testbench/shr_master_model.sv
`timescale 1ns/1ps

module shr_master_model (
  // clock
  input wire logic hclk,
  // slave side
  input wire shr_pkg::shr_resp_t response,
  input wire logic slave_oe,
  input wire logic [31:0] slave_data,
  // master side
  output shr_pkg::shr_bus_req_t bus_req,
  output logic [31:0] bus_level
);
  import shr_pkg::*;
  logic drv = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] held = 32'h0;
  logic master_request = 1'b0;
  logic master_grant = 1'b0;
  logic bus_lock = 1'b0;

  // --------------------------------------------------------------
  // data bus level
  // --------------------------------------------------------------
  // released bus shows the inverse of its last level, so stale data never passes
  assign bus_level = slave_oe ? slave_data : (drv ? wdat : ~held);
  always @(posedge hclk) begin
    held <= bus_level;
  end
  initial bus_req = '0;

  // --------------------------------------------------------------
  // one-master arbiter
  // --------------------------------------------------------------
  // grant follows the request; a locked owner keeps the bus
  always @(posedge hclk) begin
    master_grant <= master_request || (master_grant && bus_lock);
  end

  task automatic xfer(input logic [1:0] tt, input logic [31:0] a, input logic w,
    input logic [1:0] sz, input logic [1:0] pr, input logic [31:0] d,
    output shr_resp_t r, output shr_resp_t p, output logic [31:0] q, output int n);
    n = 0;
    r = RESP_WAIT;
    p = RESP_WAIT;
    q = 32'h0;
    @(posedge hclk);
    master_request <= 1'b1;
    // single transfers: never locked to the next one
    bus_lock <= 1'b0;
    while (master_grant !== 1'b1) @(posedge hclk);
    bus_req <= '{tt, a, w, sz, pr};
    wdat <= d;
    drv <= w && (tt == TT_SEQ);
    @(posedge hclk);
    drv <= w;
    while (r.wait_resp !== 1'b0 && n < 2000) begin
      @(posedge hclk);
      n++;
      p = r;
      r = response;
      q = bus_level;
    end
    bus_req <= '0;
    drv <= 1'b0;
    master_request <= 1'b0;
  endtask
endmodule

// ### testbench/shared_bus_response_data_arbitration_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module shared_bus_response_data_arbitration_tb;
  import shr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  shr_bus_req_t req;
  shr_resp_t resp;
  wire resp_oe;
  wire sel;
  wire d_oe;
  wire [31:0] d_out;
  wire [31:0] d_lvl;
  int n_tests = 0;
  int n_mismatch = 0;
  int n_sel = 0;
  shr_resp_t r;
  shr_resp_t p;
  logic [31:0] q;
  int n;
  logic [31:0] ea [4] = '{32'h100, 32'h11, 32'h10, 32'h80};
  logic [1:0] es [4] = '{SZ_WORD, SZ_WORD, 2'h3, SZ_WORD};

  always #10 hclk = ~hclk;

  // cycles with slave_select high: the slave's wait and withdraw cycles, not its final response
  always @(posedge hclk) begin
    if (sel === 1'b1) begin
      n_sel <= n_sel + 1;
    end
  end

  shr_bus_slave uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .bus_req(req),
    .response(resp), .resp_oe(resp_oe), .slave_select(sel),
    .shared_data_bus_in(d_lvl), .shared_data_bus_out(d_out), .shared_data_bus_oe(d_oe)
  );

  shr_master_model mst (
    .hclk(hclk), .response(resp), .slave_oe(d_oe), .slave_data(d_out),
    .bus_req(req), .bus_level(d_lvl)
  );

  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic reg_access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  // write data is derived from the address so a read back proves the word
  task automatic sx(input logic [1:0] tt, input logic [31:0] a, input logic w,
    input logic [1:0] sz, input logic [1:0] pr, input shr_resp_t er, input int en);
    int k;
    k = n_sel;
    mst.xfer(tt, a, w, sz, pr, a ^ 32'h5A5A_0000, r, p, q, n);
    `CHK(r, er)
    `CHK(n_sel - k, n - 1)
    if (en >= 0) begin
      `CHK(n, en)
    end
  endtask

  task automatic tend(input string s);
    $display("test %s ended", s);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    $display("watchdog expired");
    stop_test;
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    `CHK({resp_oe, d_oe, hresp}, 3'b000)
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(resp, RESP_DONE)
    `CHK({resp_oe, sel}, 2'b10)
    reg_access(1'b0, CTRL_OFF, 32'h0);
    `CHK(q, CTRL_RESET)
    reg_access(1'b0, 8'hFC, 32'h0);
    `CHK(q, 32'h0)
    tend("reset");
    reg_access(1'b1, CTRL_OFF, 32'h0000_1001);
    sx(TT_NONSEQ, 32'h3C, 1'b1, SZ_WORD, 2'h2, RESP_DONE, 4);
    sx(TT_SEQ, 32'h3C, 1'b0, SZ_WORD, 2'h2, RESP_DONE, 3);
    `CHK(q, 32'h5A5A_003C)
    tend("wait");
    reg_access(1'b1, CTRL_OFF, 32'h0003_1000);
    sx(TT_NONSEQ, 32'h38, 1'b1, SZ_WORD, 2'h2, RESP_DONE, 3);
    sx(TT_SEQ, 32'h3C, 1'b1, SZ_WORD, 2'h2, RESP_LAST, 2);
    sx(TT_SEQ, 32'h3C, 1'b0, SZ_WORD, 2'h2, RESP_LAST, 3);
    `CHK(q, 32'h5A5A_003C)
    reg_access(1'b0, STAT_OFF, 32'h0);
    `CHK(q, 32'h0000_0010)
    tend("last");
    reg_access(1'b1, CTRL_OFF, 32'h000B_1000);
    for (int i = 0; i < 4; i++) begin
      sx(TT_NONSEQ, ea[i], 1'b0, es[i], 2'h0, RESP_ERROR, 1);
    end
    sx(TT_NONSEQ, 32'h80, 1'b0, SZ_WORD, 2'h2, RESP_DONE, 3);
    sx(TT_NONSEQ, 32'hC0, 1'b1, SZ_WORD, 2'h2, RESP_ERROR, -1);
    reg_access(1'b1, CTRL_OFF, 32'h0008_1000);
    sx(TT_NONSEQ, 32'hC0, 1'b1, SZ_WORD, 2'h2, RESP_DONE, -1);
    sx(TT_NONSEQ, 32'hC0, 1'b0, SZ_WORD, 2'h2, RESP_DONE, 3);
    `CHK(q, 32'h0)
    tend("error");
    reg_access(1'b1, CTRL_OFF, 32'h0004_0208);
    sx(TT_NONSEQ, 32'h3C, 1'b0, SZ_WORD, 2'h2, RESP_RETRACT, -1);
    `CHK(p, RESP_WITHDRAW_NEXT)
    reg_access(1'b1, CTRL_OFF, 32'h0000_1000);
    sx(TT_NONSEQ, 32'h3C, 1'b0, SZ_WORD, 2'h2, RESP_DONE, 3);
    `CHK(q, 32'h5A5A_003C)
    reg_access(1'b0, CNT_OFF, 32'h0);
    `CHK(q, 32'h0000_0501)
    reg_access(1'b1, CNT_OFF, 32'h0);
    reg_access(1'b0, CNT_OFF, 32'h0);
    `CHK(q, 32'h0)
    tend("retract");
    stop_test;
  end
endmodule
